//--- pulse_link_defines.svh
// timing counts and table constants for the pulse-count brightness link
`ifndef PULSE_LINK_DEFINES_SVH
`define PULSE_LINK_DEFINES_SVH

`define CLK_SYS_MHZ 25
// off timeout in microseconds and its cycle count (longest time, round down)
`define OFF_TIMEOUT_US 500
`define OFF_TIMEOUT_CYC (`OFF_TIMEOUT_US * `CLK_SYS_MHZ)
// soft-start interval in microseconds and its cycle count
`define SOFT_START_US 400
`define SOFT_START_CYC (`SOFT_START_US * `CLK_SYS_MHZ)
// fastest edge rate in kHz; host half period in cycles (least time, round up)
`define EDGE_RATE_KHZ 1000
`define HALF_PERIOD_CYC ((`CLK_SYS_MHZ * 1000 + 2 * `EDGE_RATE_KHZ - 1) / (2 * `EDGE_RATE_KHZ))
// settle time after a burst before the level reaches the output, in cycles
`define SETTLE_CYC 32
// number of current settings
`define LEVEL_COUNT 32
`define LEVEL_MAX 5'h1F
`define LEVEL_MIN 5'h00

`endif

//--- pulse_link_pkg.sv
// types shared by both ends of the pulse-count brightness link
package pulse_link_pkg;
	// level code 0..31 stands for setting 1..32
	typedef logic [4:0] level_t;
	// output current in microamps
	typedef logic [14:0] current_ua_t;
	typedef enum logic [2:0] {
		DEV_OFF = 3'h1,
		DEV_HIGH = 3'h2,
		DEV_LOW = 3'h4
	} dev_state_t;
	typedef enum logic [2:0] {
		HOST_IDLE = 3'h1,
		HOST_LOW = 3'h2,
		HOST_HIGH = 3'h4
	} host_state_t;
endpackage : pulse_link_pkg

//--- pulse_link_if.sv
// the single enable/set pulse wire between host and device
`timescale 1ns/1ps
`default_nettype none
interface pulse_link_if;
	logic pulse;
	modport host_mp (output pulse);
	modport device_mp (input pulse);
endinterface : pulse_link_if
`default_nettype wire

//--- pulse_count_device.sv
// device end: counts pin edges and selects a logarithmic current level
`timescale 1ns/1ps
`default_nettype none
`include "pulse_link_defines.svh"
module pulse_count_device (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// link
	pulse_link_if.device_mp link,
	// user side
	output logic enabled_o,
	output logic pump_on_o,
	output logic pump_ready_o,
	output pulse_link_pkg::level_t level_o,
	output pulse_link_pkg::current_ua_t current_ua_o
);
	import pulse_link_pkg::*;

	localparam logic [13:0] OFF_CYC = 14'(`OFF_TIMEOUT_CYC);
	localparam logic [13:0] SS_CYC = 14'(`SOFT_START_CYC);
	localparam logic [5:0] SETTLE = 6'(`SETTLE_CYC);

	// table current in microamps for each code
	function automatic current_ua_t level_current(input level_t lv);
		case (lv)
			5'h00: level_current = 15'h0225; // 549
			5'h01: level_current = 15'h0273; // 627
			5'h02: level_current = 15'h02C2; // 706
			5'h03: level_current = 15'h0310; // 784
			5'h04: level_current = 15'h035F; // 863
			5'h05: level_current = 15'h03FC; // 1020
			5'h06: level_current = 15'h044A; // 1098
			5'h07: level_current = 15'h04E7; // 1255
			5'h08: level_current = 15'h0584; // 1412
			5'h09: level_current = 15'h0621; // 1569
			5'h0A: level_current = 15'h070C; // 1804
			5'h0B: level_current = 15'h07A9; // 1961
			5'h0C: level_current = 15'h08E3; // 2275
			5'h0D: level_current = 15'h09CE; // 2510
			5'h0E: level_current = 15'h0B08; // 2824
			5'h0F: level_current = 15'h0C41; // 3137
			5'h10: level_current = 15'h0DC9; // 3529
			5'h11: level_current = 15'h0FA0; // 4000
			5'h12: level_current = 15'h1177; // 4471
			5'h13: level_current = 15'h139C; // 5020
			5'h14: level_current = 15'h160F; // 5647
			5'h15: level_current = 15'h18D1; // 6353
			5'h16: level_current = 15'h1B93; // 7059
			5'h17: level_current = 15'h1EF2; // 7922
			5'h18: level_current = 15'h22ED; // 8941
			5'h19: level_current = 15'h2737; // 10039
			5'h1A: level_current = 15'h2BD0; // 11216
			5'h1B: level_current = 15'h3153; // 12627
			5'h1C: level_current = 15'h3726; // 14118
			5'h1D: level_current = 15'h3DE3; // 15843
			5'h1E: level_current = 15'h458C; // 17804
			default: level_current = 15'h4E20; // 20000
		endcase
	endfunction : level_current

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic pin_d;
		dev_state_t state;
		level_t count;
		logic [13:0] low_cnt;
		logic [13:0] ss_cnt;
		logic [5:0] settle_cnt;
		logic enabled;
		logic pump_on;
		logic pump_ready;
		level_t level;
		current_ua_t current_ua;
	} dev_regs_t;

	dev_regs_t st_r;
	dev_regs_t st_nxt;
	logic rise;

	// a rising edge seen after the two-stage synchroniser
	assign rise = st_r.sync2 & ~st_r.pin_d;

	// next-state logic for the whole device
	always_comb begin
		st_nxt = st_r;
		st_nxt.sync1 = link.pulse;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.pin_d = st_r.sync2;
		case (st_r.state)
			DEV_OFF: begin
				if (rise) begin
					st_nxt.state = DEV_HIGH;
					st_nxt.count = `LEVEL_MIN;
					st_nxt.enabled = 1'b1;
					st_nxt.pump_on = 1'b1;
					st_nxt.ss_cnt = '0;
					st_nxt.settle_cnt = '0;
				end
			end
			DEV_HIGH: begin
				// pin stays high: level is held indefinitely
				if (!st_r.sync2) begin
					st_nxt.state = DEV_LOW;
					st_nxt.low_cnt = '0;
				end
			end
			default: begin
				if (rise) begin
					st_nxt.state = DEV_HIGH;
					// wrap from the top setting back to the lowest
					st_nxt.count = st_r.count + 5'h01;
					st_nxt.settle_cnt = '0;
				end else if (st_r.low_cnt == OFF_CYC - 14'h0001) begin
					st_nxt.state = DEV_OFF;
					st_nxt.count = `LEVEL_MIN;
					st_nxt.enabled = 1'b0;
					st_nxt.pump_on = 1'b0;
					st_nxt.pump_ready = 1'b0;
					st_nxt.level = `LEVEL_MIN;
					st_nxt.current_ua = '0;
				end else begin
					st_nxt.low_cnt = st_r.low_cnt + 14'h0001;
				end
			end
		endcase
		// soft-start runs alongside counting, edges are never blocked
		if (st_r.pump_on && !st_r.pump_ready && st_nxt.pump_on) begin
			if (st_r.ss_cnt == SS_CYC - 14'h0001) begin
				st_nxt.pump_ready = 1'b1;
			end else begin
				st_nxt.ss_cnt = st_r.ss_cnt + 14'h0001;
			end
		end
		// a burst must go quiet before the output follows the count,
		// so intermediate settings never reach the current sources
		if (st_r.enabled && st_nxt.enabled && !rise) begin
			if (st_r.settle_cnt == SETTLE - 6'h01) begin
				st_nxt.level = st_r.count;
				st_nxt.current_ua = level_current(st_r.count);
			end else begin
				st_nxt.settle_cnt = st_r.settle_cnt + 6'h01;
			end
		end
	end

	// state register
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= '{state: DEV_OFF, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign enabled_o = st_r.enabled;
	assign pump_on_o = st_r.pump_on;
	assign pump_ready_o = st_r.pump_ready;
	assign level_o = st_r.level;
	assign current_ua_o = st_r.current_ua;
endmodule : pulse_count_device
`default_nettype wire

//--- pulse_count_host.sv
// host end: sends a burst of pulses or shuts the device down
`timescale 1ns/1ps
`default_nettype none
`include "pulse_link_defines.svh"
module pulse_count_host (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// user request: send pulse_cnt_i pulses, or release the line
	input wire logic send_i,
	input wire logic [5:0] pulse_cnt_i,
	input wire logic release_i,
	output logic busy_o,
	// link
	pulse_link_if.host_mp link
);
	import pulse_link_pkg::*;

	localparam logic [3:0] HALF = 4'(`HALF_PERIOD_CYC);

	typedef struct packed {
		host_state_t state;
		logic pin;
		logic [5:0] left;
		logic [3:0] tick;
		logic busy;
	} host_regs_t;

	host_regs_t st_r;
	host_regs_t st_nxt;

	// pulse sequencer: low phases last one half period, well under timeout
	always_comb begin
		st_nxt = st_r;
		case (st_r.state)
			HOST_IDLE: begin
				if (send_i && pulse_cnt_i != 6'h00) begin
					st_nxt.state = HOST_LOW;
					st_nxt.left = pulse_cnt_i;
					st_nxt.pin = 1'b0;
					st_nxt.tick = '0;
				end else if (release_i) begin
					st_nxt.pin = 1'b0; // device turns off after timeout
				end
			end
			HOST_LOW: begin
				if (st_r.tick == HALF - 4'h1) begin
					st_nxt.state = HOST_HIGH;
					st_nxt.pin = 1'b1;
					st_nxt.tick = '0;
					st_nxt.left = st_r.left - 6'h01;
				end else begin
					st_nxt.tick = st_r.tick + 4'h1;
				end
			end
			default: begin
				if (st_r.tick == HALF - 4'h1) begin
					st_nxt.tick = '0;
					if (st_r.left == 6'h00) begin
						st_nxt.state = HOST_IDLE; // pin stays high
					end else begin
						st_nxt.state = HOST_LOW;
						st_nxt.pin = 1'b0;
					end
				end else begin
					st_nxt.tick = st_r.tick + 4'h1;
				end
			end
		endcase
		// busy is registered so the output comes straight from a flop
		st_nxt.busy = (st_nxt.state != HOST_IDLE);
	end

	// state register; requests are taken only in HOST_IDLE, one arriving while busy is dropped
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= '{state: HOST_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.pulse = st_r.pin;
	assign busy_o = st_r.busy;
endmodule : pulse_count_host
`default_nettype wire

//--- pulse_link_monitor.sv
// concurrent checks on the pulse wire and the device outputs
`timescale 1ns/1ps
`default_nettype none
module pulse_link_monitor (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// link and device outputs
	input wire logic pulse,
	input wire logic enabled_o,
	input wire logic pump_on_o,
	input wire logic pump_ready_o,
	input wire pulse_link_pkg::level_t level_o,
	input wire pulse_link_pkg::current_ua_t current_ua_o
);
	import pulse_link_pkg::*;
	logic pulse_q_r;
	logic [15:0] low_cnt_r;
	logic [15:0] rise_cnt_r;
	logic [15:0] pump_cnt_r;
	// low time, time since last rise and pump run time; all saturate so a
	// long idle never wraps
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pulse_q_r <= 1'b0;
			low_cnt_r <= 16'h0000;
			rise_cnt_r <= 16'h0000;
			pump_cnt_r <= 16'h0000;
		end else begin
			pump_cnt_r <= pump_on_o ? pump_cnt_r + {15'h0000, ~&pump_cnt_r} :
				16'h0000;
			pulse_q_r <= pulse;
			low_cnt_r <= pulse ? 16'h0000 : low_cnt_r + {15'h0000, ~&low_cnt_r};
			rise_cnt_r <= (pulse && !pulse_q_r) ? 16'h0000 :
				rise_cnt_r + {15'h0000, ~&rise_cnt_r};
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	sequence pin_rise_s;
		$rose(pulse) && !enabled_o;
	endsequence
	sequence powered_s;
		enabled_o && pump_on_o;
	endsequence
	enable_on_rise_a: assert property (
		pin_rise_s |-> ##[3:5] powered_s)
		else $error("device not enabled after first rise");
	held_while_high_a: assert property (
		enabled_o && pulse |=> enabled_o)
		else $error("device dropped while pin high");
	off_timeout_a: assert property (
		low_cnt_r == 16'h30DE |->
		!enabled_o && level_o == 5'h00 && current_ua_o == 15'h0000)
		else $error("device still on after off timeout");
	no_early_off_a: assert property (
		enabled_o && low_cnt_r < 16'h2EE0 |=> enabled_o)
		else $error("device shut off too early");
	off_current_a: assert property (
		!enabled_o |-> current_ua_o == 15'h0000)
		else $error("current while disabled");
	full_scale_a: assert property (
		level_o == 5'h1F |-> current_ua_o == 15'h4E20)
		else $error("top setting not full scale");
	lowest_level_a: assert property (
		current_ua_o != 15'h0000 && level_o == 5'h00 |-> current_ua_o == 15'h0225)
		else $error("lowest setting current wrong");
	burst_hidden_a: assert property (
		$changed(current_ua_o) && enabled_o |-> rise_cnt_r >= 16'h0020)
		else $error("current changed inside a burst");
	pump_order_a: assert property (pump_ready_o |-> powered_s)
		else $error("pump ready without pump running");
	soft_start_a: assert property (
		$rose(pump_on_o) |=> !pump_ready_o [*8])
		else $error("pump ready without soft start");
	// pump run time is 10000 cycles; the counter lags the pump by one edge
	soft_start_len_a: assert property (
		pump_ready_o |-> pump_cnt_r >= 16'h2710)
		else $error("pump ready before soft-start interval");
	soft_start_end_a: assert property (
		pump_on_o && pump_cnt_r == 16'h2720 |-> pump_ready_o)
		else $error("pump not ready after soft-start interval");
endmodule : pulse_link_monitor
`default_nettype wire

//--- tb.sv
// self-checking bench joining the host and device ends of the pulse link
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pulse_link_pkg::*;
	typedef struct {logic [5:0] n; level_t lv; current_ua_t ua;} row_t;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic send_i = 1'b0;
	logic release_i = 1'b0;
	logic [5:0] pulse_cnt_i = 6'h00;
	logic busy_o, enabled_o, pump_on_o, pump_ready_o;
	level_t level_o;
	current_ua_t current_ua_o;
	int fails = 0;
	int checked = 0;
	// pulses sent from off, expected code and current in uA
	row_t rows [3] = '{'{6'h01, 5'h00, 15'h0225},
		'{6'h20, 5'h1F, 15'h4E20}, '{6'h21, 5'h00, 15'h0225}};
	pulse_link_if link_if();
	pulse_count_host pulse_count_host_i (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .send_i(send_i), .pulse_cnt_i(pulse_cnt_i),
		.release_i(release_i), .busy_o(busy_o), .link(link_if.host_mp));
	pulse_count_device pulse_count_device_i (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .link(link_if.device_mp), .enabled_o(enabled_o),
		.pump_on_o(pump_on_o), .pump_ready_o(pump_ready_o),
		.level_o(level_o), .current_ua_o(current_ua_o));
	pulse_link_monitor pulse_link_monitor_i (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .pulse(link_if.pulse), .enabled_o(enabled_o),
		.pump_on_o(pump_on_o), .pump_ready_o(pump_ready_o),
		.level_o(level_o), .current_ua_o(current_ua_o));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// burst of n pulses, then room for the settle time
	task automatic send(input logic [5:0] n);
		int k;
		@(negedge clk_sys_i);
		send_i = 1'b1;
		pulse_cnt_i = n;
		@(negedge clk_sys_i);
		send_i = 1'b0;
		cmp(busy_o, 1'b1);
		for (k = 0; k < 2000 && busy_o !== 1'b0; k++) @(negedge clk_sys_i);
		repeat (50) @(negedge clk_sys_i);
		cmp(busy_o, 1'b0);
		cmp(link_if.pulse, 1'b1);
	endtask : send
	task automatic shut(input int cyc);
		@(negedge clk_sys_i);
		release_i = 1'b1;
		@(negedge clk_sys_i);
		release_i = 1'b0;
		repeat (cyc) @(negedge clk_sys_i);
	endtask : shut
	task automatic finish_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	// whole run is near 41000 cycles; give it 60000
	initial begin
		#2400000;
		fails++;
		finish_test();
	end
	initial begin
		repeat (10) @(negedge clk_sys_i);
		cmp(enabled_o, 1'b0);
		cmp(current_ua_o, 15'h0000);
		arst_n_i = 1'b1;
		foreach (rows[i]) begin
			send(rows[i].n);
			cmp(enabled_o, 1'b1);
			cmp(pump_on_o, 1'b1);
			cmp(pump_ready_o, 1'b0);
			cmp(level_o, rows[i].lv);
			cmp(current_ua_o, rows[i].ua);
			if (i < 2) shut(12600);
		end
		// a single pulse for one step up, then a burst of 31 for one step down
		send(6'h01);
		cmp(current_ua_o, 15'h0273);
		send(6'h1F);
		cmp(level_o, 5'h00);
		shut(12000);
		cmp(enabled_o, 1'b1);
		cmp(pump_ready_o, 1'b1);
		repeat (600) @(negedge clk_sys_i);
		cmp(enabled_o, 1'b0);
		cmp(pump_on_o, 1'b0);
		cmp(current_ua_o, 15'h0000);
		send(6'h01);
		cmp(level_o, 5'h00);
		// reset in mid-run with the device lit: everything drops at once
		@(negedge clk_sys_i);
		arst_n_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		cmp(enabled_o, 1'b0);
		cmp(pump_on_o, 1'b0);
		cmp(level_o, 5'h00);
		cmp(current_ua_o, 15'h0000);
		cmp(busy_o, 1'b0);
		cmp(link_if.pulse, 1'b0);
		arst_n_i = 1'b1;
		// three edges from off after the reset select the third setting
		send(6'h03);
		cmp(enabled_o, 1'b1);
		cmp(level_o, 5'h02);
		cmp(current_ua_o, 15'h02C2);
		finish_test();
	end
endmodule : tb
`default_nettype wire
